// [rtl/reic_entry_check.sv]
// Checker that flags BCD entries written to the time, calendar and alarm groups.
`timescale 1ns/1ns
`default_nettype none
module reic_entry_check #(
  parameter int GROUPS = reic_pkg::NGRP
) (
  input  wire logic              clk_i,
  input  wire logic              rstn_i,
  input  wire logic [GROUPS-1:0] entry_wr_i,
  input  wire logic [7:0]        entry_f0_i,
  input  wire logic [7:0]        entry_f1_i,
  input  wire logic [7:0]        entry_f2_i,
  reic_link_if.chk_src           link
);
  if (GROUPS != reic_pkg::NGRP) begin : g_bad_groups
    $error("reic_entry_check: GROUPS must equal the size of the check tables");
  end

  logic [GROUPS-1:0] grp_ok;
  for (genvar g = 0; g < GROUPS; g++) begin : g_grp
    assign grp_ok[g] =
      reic_pkg::reic_field_ok(entry_f0_i, reic_pkg::CHK_MASK[g][0], reic_pkg::CHK_LO[g][0], reic_pkg::CHK_HI[g][0]) &&
      reic_pkg::reic_field_ok(entry_f1_i, reic_pkg::CHK_MASK[g][1], reic_pkg::CHK_LO[g][1], reic_pkg::CHK_HI[g][1]) &&
      reic_pkg::reic_field_ok(entry_f2_i, reic_pkg::CHK_MASK[g][2], reic_pkg::CHK_LO[g][2], reic_pkg::CHK_HI[g][2]);
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      link.bad_set <= '0;
      link.bad_clr <= '0;
    end else begin
      link.bad_set <= entry_wr_i & ~grp_ok; // RULE5
      link.bad_clr <= entry_wr_i & grp_ok; // RULE8
    end
  end
endmodule : reic_entry_check
`default_nettype wire

// [rtl/reic_event_irq_ctrl.sv]
// Top level of the RTC event flags, interrupt enables and entry validity logic.
// Summary of operation
// RULE1: Writing the status-clear command clears every status flag whose bit is one and leaves the rest; the code ignores bit 0, and a same-cycle event wins.
// RULE2: Writing the enable command turns on every interrupt source whose bit is one and leaves the rest.
// RULE3: Writing the disable command turns off every interrupt source whose bit is one and leaves the rest.
// RULE4: The mask register reads back the enable state of the five sources in bits 4..0 and resets to zero.
// RULE5: Bit 0 of the valid-entry register is set when invalid time data is written, else it reads zero.
// RULE6: Bit 1 of the valid-entry register is set when invalid calendar data is written, else zero.
// RULE7: Bit 2 of the valid-entry register is set when invalid time-alarm data is written, else zero.
// RULE8: Bit 3 of the valid-entry register is set when invalid calendar-alarm data is written, else zero.
// RULE9: The update-acknowledge flag is one while the clock is stopped and zero while it runs.
// RULE10: The time and calendar event flags rise on the tick picked by their selection fields.
// RULE11: The interrupt output is high while any status flag is set with its mask bit one.
`timescale 1ns/1ns
`default_nettype none

module reic_event_irq_ctrl (
  input  wire logic                          clk_i,
  input  wire logic                          rstn_i,
  input  wire logic [reic_pkg::ADDR_W-1:0]   addr_i,
  input  wire logic [reic_pkg::DATA_W-1:0]   wdata_i,
  input  wire logic                          wr_i,
  input  wire logic                          rd_i,
  output var  logic [reic_pkg::DATA_W-1:0]   rdata_o,
  output var  logic                          irq_o,
  input  wire logic                          clock_stopped_i,
  input  wire logic                          alarm_match_i,
  input  wire logic                          second_tick_i,
  input  wire logic                          minute_tick_i,
  input  wire logic                          hour_tick_i,
  input  wire logic                          noon_tick_i,
  input  wire logic                          midnight_tick_i,
  input  wire logic                          week_tick_i,
  input  wire logic                          month_tick_i,
  input  wire logic                          year_tick_i,
  input  wire logic [reic_pkg::NGRP-1:0]     entry_wr_i,
  input  wire logic [7:0]                    entry_f0_i,
  input  wire logic [7:0]                    entry_f1_i,
  input  wire logic [7:0]                    entry_f2_i
);

  logic [reic_pkg::NSRC-1:0] status;
  logic [reic_pkg::NSRC-1:0] mask;
  logic [reic_pkg::NGRP-1:0] valid;
  logic [3:0]                ctrl;

  reic_link_if link ();

  reic_pkg::reic_tev_sel_t tev_sel;
  reic_pkg::reic_cev_sel_t cev_sel;
  assign tev_sel = reic_pkg::reic_tev_sel_t'(ctrl[reic_pkg::TSEL_LSB +: 2]);
  assign cev_sel = reic_pkg::reic_cev_sel_t'(ctrl[reic_pkg::CSEL_LSB +: 2]);

  // Register port decode.
  wire logic wr_clear   = wr_i && (addr_i == reic_pkg::CLEAR_OFS);
  wire logic wr_enable  = wr_i && (addr_i == reic_pkg::ENABLE_OFS);
  wire logic wr_disable = wr_i && (addr_i == reic_pkg::DISABLE_OFS);
  wire logic wr_ctrl    = wr_i && (addr_i == reic_pkg::CTRL_OFS);
  wire logic rd_status  = rd_i && (addr_i == reic_pkg::STATUS_OFS);
  wire logic rd_mask    = rd_i && (addr_i == reic_pkg::MASK_OFS);
  wire logic rd_valid   = rd_i && (addr_i == reic_pkg::VALID_OFS);
  wire logic rd_ctrl    = rd_i && (addr_i == reic_pkg::CTRL_OFS);

  wire logic [reic_pkg::NSRC-1:0] wbits    = wdata_i[reic_pkg::NSRC-1:0];
  wire logic [reic_pkg::NSRC-1:0] evt      = link.event_pulse;
  wire logic [reic_pkg::NSRC-1:0] clr_bits = wr_clear ? wbits : '0;
  wire logic [reic_pkg::NSRC-1:0] en_bits  = wr_enable ? wbits : '0;
  wire logic [reic_pkg::NSRC-1:0] dis_bits = wr_disable ? wbits : '0;

  // The acknowledge flag is dropped as soon as the clock runs again, so
  // software never sees a stale permission to update the counters.
  wire logic [reic_pkg::NSRC-1:0] ack_drop = ~evt & reic_pkg::ACK_ONLY;

  // A set in the same cycle as a clear wins, so no event is lost.
  wire logic [reic_pkg::NSRC-1:0] next_status = (status & ~clr_bits & ~ack_drop) | evt; // RULE1
  wire logic [reic_pkg::NSRC-1:0] next_mask   = (mask | en_bits) & ~dis_bits; // RULE2
  wire logic [reic_pkg::NGRP-1:0] next_valid  = (valid & ~link.bad_clr) | link.bad_set; // RULE6
  wire logic [3:0]                next_ctrl   = wr_ctrl ? wdata_i[3:0] : ctrl;
  wire logic                      next_irq    = |(next_status & next_mask); // RULE11

  // Write-only commands and unmapped addresses read as zero.
  wire logic [reic_pkg::DATA_W-1:0] next_rdata =
    rd_status ? reic_pkg::DATA_W'(status) :
    rd_mask   ? reic_pkg::DATA_W'(mask) : // RULE4
    rd_valid  ? reic_pkg::DATA_W'(valid) :
    rd_ctrl   ? reic_pkg::DATA_W'(ctrl) : '0;

  reic_event_select u_event (
    .clk_i           (clk_i),
    .rstn_i          (rstn_i),
    .time_sel_i      (tev_sel),
    .cal_sel_i       (cev_sel),
    .clock_stopped_i (clock_stopped_i),
    .alarm_match_i   (alarm_match_i),
    .second_tick_i   (second_tick_i),
    .minute_tick_i   (minute_tick_i),
    .hour_tick_i     (hour_tick_i),
    .noon_tick_i     (noon_tick_i),
    .midnight_tick_i (midnight_tick_i),
    .week_tick_i     (week_tick_i),
    .month_tick_i    (month_tick_i),
    .year_tick_i     (year_tick_i),
    .link            (link.evt_src)
  );

  reic_entry_check #(
    .GROUPS (reic_pkg::NGRP)
  ) u_check (
    .clk_i      (clk_i),
    .rstn_i     (rstn_i),
    .entry_wr_i (entry_wr_i),
    .entry_f0_i (entry_f0_i),
    .entry_f1_i (entry_f1_i),
    .entry_f2_i (entry_f2_i),
    .link       (link.chk_src)
  );

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      status <= reic_pkg::STATUS_RST;
    end else begin
      status <= next_status; // RULE9
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mask <= reic_pkg::MASK_RST; // RULE4
    end else begin
      mask <= next_mask; // RULE3
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      valid <= reic_pkg::VALID_RST;
    end else begin
      valid <= next_valid; // RULE7
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl <= reic_pkg::CTRL_RST;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= '0;
      irq_o   <= 1'b0;
    end else begin
      rdata_o <= next_rdata;
      irq_o   <= next_irq;
    end
  end

  // Checks on the behaviour above.
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);

  a_clear_drops_flag: assert property ( // RULE1
    wr_clear |=> ((status & $past(wbits) & ~$past(evt)) == '0))
    else $error("status flag survived a clear command");

  a_clear_zero_keeps: assert property ( // RULE1
    wr_clear |=> (($past(status) & ~$past(wbits) & ~$past(ack_drop) & ~status) == '0))
    else $error("status flag lost although its clear bit was zero");

  a_enable_sets_mask: assert property ( // RULE2
    wr_enable |=> (mask == ($past(mask) | $past(wbits))))
    else $error("enable command did not update the mask as expected");

  a_disable_drops_mask: assert property ( // RULE3
    wr_disable |=> (mask == ($past(mask) & ~$past(wbits))))
    else $error("disable command did not update the mask as expected");

  a_mask_holds_idle: assert property ( // RULE4
    !(wr_enable || wr_disable) |=> $stable(mask))
    else $error("mask changed without an enable or disable command");

  a_mask_read_back: assert property ( // RULE4
    rd_mask |=> (rdata_o == reic_pkg::DATA_W'($past(mask))))
    else $error("mask read returned wrong data");

  a_bad_time_flag: assert property ( // RULE5
    (entry_wr_i[0] && (entry_f0_i[3:0] > 4'h9)) |-> ##2 valid[0])
    else $error("invalid time entry not flagged");

  a_bad_cal_flag: assert property ( // RULE6
    (entry_wr_i[1] && ((entry_f1_i[4:0] == 5'h00) || (entry_f1_i[4:0] > 5'h12))) |-> ##2 valid[1])
    else $error("invalid calendar entry not flagged");

  a_bad_talarm_flag: assert property ( // RULE7
    (entry_wr_i[2] && ((entry_f1_i[6:4] > 3'h5) || (entry_f2_i[5:0] > 6'h23))) |-> ##2 valid[2])
    else $error("invalid time alarm entry not flagged");

  a_bad_calarm_flag: assert property ( // RULE8
    (entry_wr_i[3] && ((entry_f0_i[5:0] == 6'h00) || (entry_f0_i[5:0] > 6'h31))) |-> ##2 valid[3])
    else $error("invalid calendar alarm entry not flagged");

  a_valid_needs_cause: assert property ( // RULE5
    ((valid & ~$past(valid)) != '0) |-> ($past(entry_wr_i, 2) != '0))
    else $error("entry flag rose without a write");

  a_ack_tracks_stop: assert property ( // RULE9
    ##2 (status[reic_pkg::ACK_BIT] == $past(clock_stopped_i, 2)))
    else $error("update acknowledge does not follow the clock stop");

  a_time_event_min: assert property ( // RULE10
    (minute_tick_i && (tev_sel == reic_pkg::REIC_TEV_MINUTE)) |-> ##2 status[reic_pkg::TIME_BIT])
    else $error("minute time event not flagged");

  a_cal_event_month: assert property ( // RULE10
    (month_tick_i && (cev_sel == reic_pkg::REIC_CEV_MONTH)) |-> ##2 status[reic_pkg::CAL_BIT])
    else $error("month calendar event not flagged");

  a_irq_level_match: assert property ( // RULE11
    irq_o == |(status & mask))
    else $error("interrupt output disagrees with flags and mask");

  a_rdata_idle_zero: assert property ( // RULE4
    !rd_i |=> (rdata_o == '0))
    else $error("read data did not return to zero");

  a_cmd_reads_zero: assert property ( // RULE3
    (rd_i && ((addr_i == reic_pkg::CLEAR_OFS) || (addr_i == reic_pkg::ENABLE_OFS) ||
              (addr_i == reic_pkg::DISABLE_OFS))) |=> (rdata_o == '0))
    else $error("write-only command register returned data");

  a_status_read_back: assert property ( // RULE9
    rd_status |=> (rdata_o == reic_pkg::DATA_W'($past(status))))
    else $error("status read returned wrong data");

  a_valid_read_back: assert property ( // RULE5
    rd_valid |=> (rdata_o == reic_pkg::DATA_W'($past(valid))))
    else $error("valid-entry read returned wrong data");

  // Only the acknowledge flag may fall on its own; every other flag is sticky.
  a_flag_needs_clear: assert property ( // RULE1
    !wr_clear |=> ((($past(status) & ~status) & ~reic_pkg::ACK_ONLY) == '0))
    else $error("event flag fell without a clear command");

  a_alarm_sets_flag: assert property ( // RULE1
    alarm_match_i |-> ##2 status[reic_pkg::ALARM_BIT])
    else $error("alarm match not flagged");

  a_second_sets_flag: assert property ( // RULE1
    second_tick_i |-> ##2 status[reic_pkg::SEC_BIT])
    else $error("second tick not flagged");

  a_time_event_hour: assert property ( // RULE10
    (hour_tick_i && (tev_sel == reic_pkg::REIC_TEV_HOUR)) |-> ##2 status[reic_pkg::TIME_BIT])
    else $error("hour time event not flagged");

  a_time_event_noon: assert property ( // RULE10
    (noon_tick_i && (tev_sel == reic_pkg::REIC_TEV_NOON)) |-> ##2 status[reic_pkg::TIME_BIT])
    else $error("noon time event not flagged");

  a_time_event_night: assert property ( // RULE10
    (midnight_tick_i && (tev_sel == reic_pkg::REIC_TEV_MIDNIGHT)) |-> ##2 status[reic_pkg::TIME_BIT])
    else $error("midnight time event not flagged");

  a_cal_event_week: assert property ( // RULE10
    (week_tick_i && (cev_sel == reic_pkg::REIC_CEV_WEEK)) |-> ##2 status[reic_pkg::CAL_BIT])
    else $error("week calendar event not flagged");

  a_cal_event_year: assert property ( // RULE10
    (year_tick_i && (cev_sel == reic_pkg::REIC_CEV_YEAR)) |-> ##2 status[reic_pkg::CAL_BIT])
    else $error("year calendar event not flagged");

  a_cal_none_quiet: assert property ( // RULE10
    (cev_sel == reic_pkg::REIC_CEV_NONE) |=> !evt[reic_pkg::CAL_BIT])
    else $error("calendar event raised with no selection");

  a_ctrl_write_lands: assert property ( // RULE10
    wr_ctrl |=> (ctrl == $past(wdata_i[3:0])))
    else $error("control write did not land");

  a_ctrl_holds_idle: assert property ( // RULE10
    !wr_ctrl |=> $stable(ctrl))
    else $error("control changed without a write");

  a_valid_clears_good: assert property ( // RULE6
    (link.bad_clr != '0) |=> ((valid & $past(link.bad_clr)) == '0))
    else $error("entry flag kept after a valid write");

  c_irq_raise: cover property ($rose(irq_o));
  c_set_beats_clear: cover property (wr_clear && ((wbits & evt) != '0));
  c_bad_calendar: cover property ($rose(valid[1]));
  c_mask_full: cover property (mask == 5'h1F);
  c_valid_cleared: cover property ($fell(valid[0]));

endmodule : reic_event_irq_ctrl
`default_nettype wire

// [rtl/reic_event_select.sv]
// Event selector that turns RTC ticks into status flag set requests.
`timescale 1ns/1ns
`default_nettype none
module reic_event_select (
  input  wire logic                    clk_i,
  input  wire logic                    rstn_i,
  input  wire reic_pkg::reic_tev_sel_t time_sel_i,
  input  wire reic_pkg::reic_cev_sel_t cal_sel_i,
  input  wire logic                    clock_stopped_i,
  input  wire logic                    alarm_match_i,
  input  wire logic                    second_tick_i,
  input  wire logic                    minute_tick_i,
  input  wire logic                    hour_tick_i,
  input  wire logic                    noon_tick_i,
  input  wire logic                    midnight_tick_i,
  input  wire logic                    week_tick_i,
  input  wire logic                    month_tick_i,
  input  wire logic                    year_tick_i,
  reic_link_if.evt_src                 link
);
  wire logic time_hit = (time_sel_i == reic_pkg::REIC_TEV_MINUTE) ? minute_tick_i :
                        (time_sel_i == reic_pkg::REIC_TEV_HOUR)   ? hour_tick_i :
                        (time_sel_i == reic_pkg::REIC_TEV_NOON)   ? noon_tick_i : midnight_tick_i;
  wire logic cal_hit  = (cal_sel_i == reic_pkg::REIC_CEV_WEEK)  ? week_tick_i :
                        (cal_sel_i == reic_pkg::REIC_CEV_MONTH) ? month_tick_i :
                        (cal_sel_i == reic_pkg::REIC_CEV_YEAR)  ? year_tick_i : 1'b0;
  // Bit 0 is a level: it stays high for as long as the clock is stopped.
  wire logic [reic_pkg::NSRC-1:0] next_event = {cal_hit, time_hit, second_tick_i, alarm_match_i, clock_stopped_i};

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      link.event_pulse <= '0;
    end else begin
      link.event_pulse <= next_event; // RULE10
    end
  end
endmodule : reic_event_select
`default_nettype wire

// [rtl/reic_link_if.sv]
// Internal carrier between the event selector, the entry checker and the top.
`timescale 1ns/1ns
`default_nettype none
interface reic_link_if;
  logic [reic_pkg::NSRC-1:0] event_pulse;
  logic [reic_pkg::NGRP-1:0] bad_set;
  logic [reic_pkg::NGRP-1:0] bad_clr;
  modport evt_src (output event_pulse);
  modport chk_src (output bad_set, output bad_clr);
  modport sink    (input event_pulse, input bad_set, input bad_clr);
endinterface : reic_link_if
`default_nettype wire

// [rtl/reic_pkg.sv]
// Shared constants and types of the RTC event flag and interrupt control.
package reic_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int NSRC   = 5;
  localparam int NGRP   = 4;

  localparam logic [ADDR_W-1:0] STATUS_OFS  = 8'h58;
  localparam logic [ADDR_W-1:0] CLEAR_OFS   = 8'h5C;
  localparam logic [ADDR_W-1:0] ENABLE_OFS  = 8'h60;
  localparam logic [ADDR_W-1:0] DISABLE_OFS = 8'h64;
  localparam logic [ADDR_W-1:0] MASK_OFS    = 8'h68;
  localparam logic [ADDR_W-1:0] VALID_OFS   = 8'h6C;
  localparam logic [ADDR_W-1:0] CTRL_OFS    = 8'h70;

  localparam int ACK_BIT   = 0;
  localparam int ALARM_BIT = 1;
  localparam int SEC_BIT   = 2;
  localparam int TIME_BIT  = 3;
  localparam int CAL_BIT   = 4;

  localparam logic [NSRC-1:0] ACK_ONLY   = 5'h01;
  localparam logic [NSRC-1:0] STATUS_RST = 5'h00;
  localparam logic [NSRC-1:0] MASK_RST   = 5'h00;
  localparam logic [NGRP-1:0] VALID_RST  = 4'h0;
  localparam logic [3:0]      CTRL_RST   = 4'h0;
  localparam int TSEL_LSB = 0;
  localparam int CSEL_LSB = 2;

  typedef enum logic [1:0] {
    REIC_TEV_MINUTE = 2'b00, REIC_TEV_HOUR = 2'b01, REIC_TEV_NOON = 2'b10, REIC_TEV_MIDNIGHT = 2'b11
  } reic_tev_sel_t;
  typedef enum logic [1:0] {
    REIC_CEV_WEEK = 2'b00, REIC_CEV_MONTH = 2'b01, REIC_CEV_YEAR = 2'b10, REIC_CEV_NONE = 2'b11
  } reic_cev_sel_t;

  // Groups: time, calendar, time alarm, calendar alarm; fields 0..2 per group.
  localparam logic [NGRP-1:0][2:0][7:0] CHK_MASK =
    {{8'h00, 8'h1F, 8'h3F}, {8'h3F, 8'h7F, 8'h7F}, {8'hFF, 8'h1F, 8'h3F}, {8'h3F, 8'h7F, 8'h7F}};
  localparam logic [NGRP-1:0][2:0][7:0] CHK_LO =
    {{8'h00, 8'h01, 8'h01}, {8'h00, 8'h00, 8'h00}, {8'h00, 8'h01, 8'h01}, {8'h00, 8'h00, 8'h00}};
  localparam logic [NGRP-1:0][2:0][7:0] CHK_HI =
    {{8'h00, 8'h12, 8'h31}, {8'h23, 8'h59, 8'h59}, {8'h99, 8'h12, 8'h31}, {8'h23, 8'h59, 8'h59}};

  function automatic logic reic_field_ok(input logic [7:0] v, input logic [7:0] m,
                                         input logic [7:0] lo, input logic [7:0] hi);
    logic [7:0] f;
    f = v & m;
    return (f[7:4] <= 4'h9) && (f[3:0] <= 4'h9) && (f >= lo) && (f <= hi);
  endfunction : reic_field_ok
endpackage : reic_pkg

// [verification/tb_reic_event_irq_ctrl.sv]
// Self-checking testbench of the RTC event flag and interrupt control block.
`timescale 1ns/1ns
`default_nettype none
module tb_reic_event_irq_ctrl;
  localparam int LIMIT = 5000;
  // Groups are packed {cal alarm, time alarm, calendar, time}, fields {f2, f1, f0}.
  localparam logic [3:0][2:0][7:0] GOOD = {{8'h00, 8'h06, 8'h15}, {8'h12, 8'h45, 8'hB0},
                                           {8'h24, 8'h06, 8'h15}, {8'h12, 8'h45, 8'h30}};
  localparam logic [3:0][2:0][7:0] BAD  = {{8'h00, 8'h06, 8'h00}, {8'h24, 8'h45, 8'h30},
                                           {8'h24, 8'h13, 8'h15}, {8'h12, 8'h45, 8'h6A}};
  logic       clk_i;
  logic       rstn_i;
  logic [7:0] addr_i;
  logic [7:0] wdata_i;
  logic       wr_i;
  logic       rd_i;
  logic [7:0] rdata_o;
  logic       irq_o;
  logic       clock_stopped_i;
  logic [8:0] ticks;
  logic [3:0] entry_wr_i;
  logic [7:0] entry_f0_i;
  logic [7:0] entry_f1_i;
  logic [7:0] entry_f2_i;
  int         err_total;
  int         check_count;
  int         cycles;
  logic [8:0] sel;
  logic [4:0] acc;

  reic_event_irq_ctrl reic_event_irq_ctrl_inst (
    .clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .irq_o(irq_o), .clock_stopped_i(clock_stopped_i),
    .alarm_match_i(ticks[0]), .second_tick_i(ticks[1]), .minute_tick_i(ticks[2]), .hour_tick_i(ticks[3]),
    .noon_tick_i(ticks[4]), .midnight_tick_i(ticks[5]), .week_tick_i(ticks[6]), .month_tick_i(ticks[7]),
    .year_tick_i(ticks[8]), .entry_wr_i(entry_wr_i), .entry_f0_i(entry_f0_i), .entry_f1_i(entry_f1_i),
    .entry_f2_i(entry_f2_i)
  );

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic summarize();
    if (err_total == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected data at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp8

  task automatic cmp1(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected irq at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp1

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask : wr

  // Read data only stand in the cycle after the strobe, so they are sampled there.
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1;
    cmp8(rdata_o, exp);
  endtask : rd

  // Status lands two cycles after the tick, so two extra edges pass before any check.
  task automatic tick(input logic [8:0] v);
    @(posedge clk_i);
    ticks <= v;
    @(posedge clk_i);
    ticks <= 9'h000;
    repeat (2) @(posedge clk_i);
    #1;
  endtask : tick

  task automatic entry(input int g, input logic [2:0][7:0] f);
    @(posedge clk_i);
    entry_wr_i <= 4'h1 << g;
    entry_f0_i <= f[0];
    entry_f1_i <= f[1];
    entry_f2_i <= f[2];
    @(posedge clk_i);
    entry_wr_i <= 4'h0;
    repeat (2) @(posedge clk_i);
  endtask : entry

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      err_total++;
      summarize();
    end
  end

  initial begin
    err_total = 0;
    check_count = 0;
    cycles = 0;
    rstn_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 8'h00;
    wr_i = 1'b0;
    rd_i = 1'b0;
    clock_stopped_i = 1'b0;
    ticks = 9'h000;
    entry_wr_i = 4'h0;
    entry_f0_i = 8'h00;
    entry_f1_i = 8'h00;
    entry_f2_i = 8'h00;
    repeat (19) @(posedge clk_i);
    #1;
    cmp1(irq_o, 1'b0);
    cmp8(rdata_o, 8'h00);
    @(posedge clk_i);
    rstn_i <= 1'b1;
    rd(reic_pkg::MASK_OFS, 8'h00);
    rd(reic_pkg::STATUS_OFS, 8'h00);
    rd(reic_pkg::VALID_OFS, 8'h00);
    rd(8'hFF, 8'h00);
    wr(reic_pkg::ENABLE_OFS, 8'h15);
    rd(reic_pkg::MASK_OFS, 8'h15);
    wr(reic_pkg::ENABLE_OFS, 8'h0A);
    rd(reic_pkg::MASK_OFS, 8'h1F);
    wr(reic_pkg::DISABLE_OFS, 8'h05);
    rd(reic_pkg::MASK_OFS, 8'h1A);
    wr(reic_pkg::MASK_OFS, 8'h00);
    rd(reic_pkg::MASK_OFS, 8'h1A);
    @(posedge clk_i);
    #1;
    cmp8(rdata_o, 8'h00);
    rd(reic_pkg::DISABLE_OFS, 8'h00);
    tick(9'h002);
    cmp1(irq_o, 1'b0);
    tick(9'h001);
    cmp1(irq_o, 1'b1);
    wr(reic_pkg::CLEAR_OFS, 8'h02);
    rd(reic_pkg::STATUS_OFS, 8'h04);
    cmp1(irq_o, 1'b0);
    wr(reic_pkg::ENABLE_OFS, 8'h1F);
    wr(reic_pkg::CTRL_OFS, 8'h00);
    tick(9'h047);
    rd(reic_pkg::STATUS_OFS, 8'h1E);
    wr(reic_pkg::CLEAR_OFS, 8'hEA);
    rd(reic_pkg::STATUS_OFS, 8'h14);
    cmp1(irq_o, 1'b1);
    wr(reic_pkg::CLEAR_OFS, 8'h14);
    rd(reic_pkg::STATUS_OFS, 8'h00);
    cmp1(irq_o, 1'b0);
    // Each time selection must ignore the other three time candidates.
    for (int s = 0; s < 4; s++) begin
      sel = 9'h004 << s;
      wr(reic_pkg::CTRL_OFS, 8'(s) | 8'h0C);
      rd(reic_pkg::CTRL_OFS, 8'(s) | 8'h0C);
      wr(reic_pkg::CLEAR_OFS, 8'h1F);
      tick(9'h03C & ~sel);
      rd(reic_pkg::STATUS_OFS, 8'h00);
      tick(sel);
      rd(reic_pkg::STATUS_OFS, 8'h08);
    end
    for (int s = 0; s < 4; s++) begin
      sel = (s < 3) ? (9'h040 << s) : 9'h000;
      wr(reic_pkg::CTRL_OFS, 8'(s) << 2);
      wr(reic_pkg::CLEAR_OFS, 8'h1F);
      tick(9'h1C0 & ~sel);
      rd(reic_pkg::STATUS_OFS, 8'h00);
      tick(sel);
      rd(reic_pkg::STATUS_OFS, (s < 3) ? 8'h10 : 8'h00);
    end
    wr(reic_pkg::CLEAR_OFS, 8'h1F);
    @(posedge clk_i);
    clock_stopped_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rd(reic_pkg::STATUS_OFS, 8'h01);
    cmp1(irq_o, 1'b1);
    wr(reic_pkg::CLEAR_OFS, 8'h01);
    rd(reic_pkg::STATUS_OFS, 8'h01);
    @(posedge clk_i);
    clock_stopped_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rd(reic_pkg::STATUS_OFS, 8'h00);
    cmp1(irq_o, 1'b0);
    // Bad entries accumulate per group; a good entry clears only its own group.
    acc = 5'h00;
    for (int g = 0; g < 4; g++) begin
      entry(g, BAD[g]);
      acc[g] = 1'b1;
      rd(reic_pkg::VALID_OFS, {3'h0, acc});
    end
    for (int g = 0; g < 4; g++) begin
      entry(g, GOOD[g]);
      acc[g] = 1'b0;
      rd(reic_pkg::VALID_OFS, {3'h0, acc});
    end
    summarize();
  end
endmodule : tb_reic_event_irq_ctrl
`default_nettype wire
